// >>> rtl/psc_ctrl_top.sv
// Host controller that sequences a 1M x 16 pseudo-SRAM over its asynchronous pins
//
// Overview of operation
// RULE_01: Memory holds 1M words of 16 bits, 20 address lines, 16 data lines.
// RULE_02: Low lane select governs bits 7..0, high lane select bits 15..8.
// RULE_03: Chip deselected with standby-select high keeps data, floats bus.
// RULE_04: Chip deselected with standby-select low loses data, floats bus.
// RULE_05: Standby-select stays high except when deep standby is wanted.
// RULE_06: Selected with output enable and write strobe high floats both lanes.
// RULE_07: Read drives only lanes whose select is low.
// RULE_08: Write strobe low writes selected lanes whatever output enable is.
// RULE_09: Write with both lane selects high is aborted, word unchanged.
// RULE_10: After power-up no input toggles for at least 200 us.
// RULE_11: At least three reads follow the wait before normal accesses.
// RULE_12: Chip select and standby-select stay high during the wait.
// RULE_13: Standby-select stays high through the wait and the three reads.
// RULE_14: Address during the initial reads is don't care.
// RULE_15: Each initial read is its own chip-select pulse.
// RULE_16: Output enable preferably high during the initial reads.
// RULE_17: Controller never drives data while output enable is low.
// RULE_18: Write strobe stays high during a read cycle.
// RULE_19: Read cycle lasts between the grade minimum and 10 us.
// RULE_20: Same-address cycles under held chip select sum to at most 10 us.
// RULE_21: Write cycle lasts between the grade minimum and 10 us.
// RULE_22: Leaving deep standby repeats the full power-on initialization.
// RULE_23: Requests are held off until the wait and dummy reads complete.
//
// Chosen here: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
module psc_ctrl_top #(
  parameter int PWR_WAIT_CYC = psc_pkg::PWR_WAIT_CYC_DEF
) (
  // Clock, reset and clock enable
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic ce,
  // AXI4-Lite write channels
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read channels
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Memory control pins
  output logic chipSelN,
  output logic outEnN,
  output logic writeStrobeN,
  output logic lowLaneSelN,
  output logic highLaneSelN,
  output logic standbySel,
  // Memory address and data pins
  output logic [19:0] wordAddr,
  output logic [15:0] dataBusOut,
  output logic dataBusOeN,
  input wire logic [15:0] dataBusIn
);
  localparam logic [15:0] PWR_LAST = 16'(PWR_WAIT_CYC - 1);

  typedef struct packed {
    psc_pkg::psc_state_t st;
    logic [15:0] cnt;
    logic [1:0] nReads;
    logic initDone;
    logic isWrite;
    logic ack;
    logic rdDone;
    logic csN;
    logic oeN;
    logic weN;
    logic lbN;
    logic ubN;
    logic modeSel;
    logic [19:0] addr;
    logic [15:0] dout;
    logic doeN;
    logic [15:0] rdData;
  } psc_core_t;

  localparam psc_core_t CORE_RST = '{
    st: psc_pkg::ST_PWR_WAIT, csN: 1'b1, oeN: 1'b1, weN: 1'b1, lbN: 1'b1, ubN: 1'b1,
    modeSel: 1'b1, doeN: 1'b1, default: '0
  };

  psc_cmd_if cmd();
  psc_core_t q, n;

  // Register slave; the pending go bit stays set until this sequencer acks it
  psc_axil_regs regs (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .ce(ce),
    .awaddr(s_axi_awaddr),
    .awvalid(s_axi_awvalid),
    .awready(s_axi_awready),
    .wdata(s_axi_wdata),
    .wstrb(s_axi_wstrb),
    .wvalid(s_axi_wvalid),
    .wready(s_axi_wready),
    .bresp(s_axi_bresp),
    .bvalid(s_axi_bvalid),
    .bready(s_axi_bready),
    .araddr(s_axi_araddr),
    .arvalid(s_axi_arvalid),
    .arready(s_axi_arready),
    .rdata(s_axi_rdata),
    .rresp(s_axi_rresp),
    .rvalid(s_axi_rvalid),
    .rready(s_axi_rready),
    .cmd(cmd)
  );

  // Sequencer next state
  always_comb begin
    n = q;
    n.ack = 1'b0;
    n.rdDone = 1'b0;
    case (q.st)
      psc_pkg::ST_PWR_WAIT: begin
        // Every pin parked, deselected and standby-select high [RULE_10] [RULE_12]
        n.csN = 1'b1;
        n.modeSel = 1'b1; // [RULE_05] [RULE_13]
        n.cnt = q.cnt + 16'h0001;
        if (q.cnt >= PWR_LAST) begin
          n.st = psc_pkg::ST_INIT_RD;
          n.cnt = '0;
          n.csN = 1'b0; // Dummy read, address left as is [RULE_14]
        end
      end
      psc_pkg::ST_INIT_RD: begin
        // Output enable kept high so nobody fights on the bus [RULE_16] [RULE_06]
        n.cnt = q.cnt + 16'h0001;
        if (q.cnt == psc_pkg::ACC_LAST) begin
          n.st = psc_pkg::ST_INIT_GAP;
          n.csN = 1'b1; // Chip select toggles between dummy reads [RULE_15]
          n.nReads = q.nReads + 2'h1; // [RULE_11]
        end
      end
      psc_pkg::ST_INIT_GAP: begin
        n.cnt = '0;
        if (q.nReads == psc_pkg::INIT_READS) begin
          n.st = psc_pkg::ST_IDLE;
          n.initDone = 1'b1; // [RULE_23]
        end else begin
          n.st = psc_pkg::ST_INIT_RD;
          n.csN = 1'b0;
        end
      end
      psc_pkg::ST_IDLE: begin
        // Deselected with standby-select high: contents kept [RULE_03]
        if (cmd.deepReq) begin
          n.st = psc_pkg::ST_DEEP;
          n.modeSel = 1'b0; // Only place standby-select goes low [RULE_05] [RULE_04]
          n.initDone = 1'b0;
        end else if (cmd.go) begin
          n.st = psc_pkg::ST_ACCESS;
          n.ack = 1'b1;
          n.cnt = '0;
          n.isWrite = cmd.isWrite;
          n.addr = cmd.addr;
          n.csN = 1'b0;
          n.lbN = !cmd.laneEn[0]; // Both low lanes off aborts a write [RULE_02] [RULE_09]
          n.ubN = !cmd.laneEn[1];
          if (cmd.isWrite) begin
            n.weN = 1'b0; // Output enable stays high anyway [RULE_08]
            n.dout = cmd.wdata;
            n.doeN = 1'b0;
          end else begin
            n.oeN = 1'b0;
            n.weN = 1'b1; // [RULE_18]
            n.doeN = 1'b1; // Bus released while the memory answers [RULE_17]
          end
        end
      end
      psc_pkg::ST_ACCESS: begin
        // Fixed cycle of ACC_CYC clocks: above the grade minimum, far below 10 us
        n.cnt = q.cnt + 16'h0001; // [RULE_19] [RULE_21]
        if (q.isWrite && q.cnt == psc_pkg::WE_RISE) begin
          n.weN = 1'b1; // Data held one more clock past the strobe edge
        end
        if (q.cnt == psc_pkg::ACC_LAST) begin
          n.st = psc_pkg::ST_RECOV;
          n.csN = 1'b1; // One access per select pulse, no same-address chains [RULE_20]
          n.oeN = 1'b1;
          n.weN = 1'b1;
          n.lbN = 1'b1;
          n.ubN = 1'b1;
          n.doeN = 1'b1;
          if (!q.isWrite) begin
            n.rdData = dataBusIn; // Lanes left unselected read as whatever floats [RULE_07]
          end
        end
      end
      psc_pkg::ST_RECOV: begin
        n.st = psc_pkg::ST_IDLE;
        n.rdDone = !q.isWrite;
      end
      psc_pkg::ST_DEEP: begin
        // Contents are lost here, so coming back means a full power-on sequence
        if (!cmd.deepReq) begin
          n.st = psc_pkg::ST_PWR_WAIT; // [RULE_22]
          n.modeSel = 1'b1;
          n.cnt = '0;
          n.nReads = '0;
        end
      end
      default: begin
        n = CORE_RST;
      end
    endcase
  end

  // State register, frozen while the clock enable is low
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= CORE_RST;
    end else if (ce) begin
      q <= n;
    end
  end

  // Pins come straight from the state register
  assign chipSelN = q.csN;
  assign outEnN = q.oeN;
  assign writeStrobeN = q.weN;
  assign lowLaneSelN = q.lbN;
  assign highLaneSelN = q.ubN;
  assign standbySel = q.modeSel;
  assign wordAddr = q.addr; // Full 20-bit word address [RULE_01]
  assign dataBusOut = q.dout;
  assign dataBusOeN = q.doeN;

  // Status back to the register block
  assign cmd.ack = q.ack;
  assign cmd.rdDone = q.rdDone;
  assign cmd.busy = q.st != psc_pkg::ST_IDLE;
  assign cmd.initDone = q.initDone;
  assign cmd.deepActive = q.st == psc_pkg::ST_DEEP;
  assign cmd.initReads = q.nReads;
  assign cmd.stateCode = q.st;
  assign cmd.rdData = q.rdData;
endmodule

// >>> include/psc_pkg.sv
// Shared constants and types for the pseudo-SRAM host controller
package psc_pkg;
  // Clock and memory timing
  localparam int CLK_NS = 10;
  localparam int CYC_MIN_NS = 95; // Slower grade, so either part works
  localparam int CYC_MAX_NS = 10000;
  localparam int ACC_CYC = (CYC_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int ACC_CYC_MAX = CYC_MAX_NS / CLK_NS;
  localparam int PWR_WAIT_US = 200;
  localparam int PWR_WAIT_CYC_DEF = (PWR_WAIT_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam logic [15:0] ACC_LAST = 16'(ACC_CYC - 1);
  localparam logic [15:0] WE_RISE = 16'(ACC_CYC - 2);
  localparam logic [1:0] INIT_READS = 2'h3;
  // Memory geometry
  localparam int ADDR_W = 20;
  localparam int DATA_W = 16;
  localparam int AXI_AW = 8;
  // Register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_WDATA = 8'h08;
  localparam logic [7:0] REG_RDATA = 8'h0C;
  localparam logic [7:0] REG_STATUS = 8'h10;
  // Field positions
  localparam int CTRL_GO = 0;
  localparam int CTRL_WRITE = 1;
  localparam int CTRL_DEEP = 2;
  localparam int WD_LANE_LO = 16;
  localparam int ST_BUSY = 0;
  localparam int ST_INIT = 1;
  localparam int ST_DEEPB = 2;
  localparam int ST_RDV = 3;
  localparam int ST_NRD = 4;
  localparam int ST_CODE = 8;
  localparam int ST_PEND = 11;
  localparam logic [1:0] LANE_RST = 2'h3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Controller sequencer states
  typedef enum logic [2:0] {
    ST_PWR_WAIT = 3'b000, ST_INIT_RD = 3'b001, ST_INIT_GAP = 3'b010, ST_IDLE = 3'b011,
    ST_ACCESS = 3'b100, ST_RECOV = 3'b101, ST_DEEP = 3'b110
  } psc_state_t;
endpackage

// >>> include/psc_cmd_if.sv
// Command and status link between register block and sequencer
`timescale 1ns/1ps
interface psc_cmd_if;
  logic go;
  logic isWrite;
  logic deepReq;
  logic [19:0] addr;
  logic [15:0] wdata;
  logic [1:0] laneEn;
  logic ack;
  logic rdDone;
  logic busy;
  logic initDone;
  logic deepActive;
  logic [1:0] initReads;
  logic [2:0] stateCode;
  logic [15:0] rdData;
  modport regs(output go, isWrite, deepReq, addr, wdata, laneEn,
               input ack, rdDone, busy, initDone, deepActive, initReads, stateCode, rdData);
  modport core(input go, isWrite, deepReq, addr, wdata, laneEn,
               output ack, rdDone, busy, initDone, deepActive, initReads, stateCode, rdData);
endinterface

// >>> rtl/psc_axil_regs.sv
// AXI4-Lite register slave holding the controller's commands and status
`timescale 1ns/1ps
module psc_axil_regs (
  // Clock, reset and clock enable
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic ce,
  // AXI4-Lite write channels
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read channels
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Sequencer side
  psc_cmd_if.regs cmd
);
  typedef struct packed {
    logic awHeld;
    logic [7:0] awAddr;
    logic wHeld;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic awReady;
    logic wReady;
    logic bValid;
    logic [1:0] bResp;
    logic arReady;
    logic rValid;
    logic [31:0] rData;
    logic [1:0] rResp;
    logic ctrlWrite;
    logic ctrlDeep;
    logic goPend;
    logic rdSticky;
    logic [19:0] addr;
    logic [15:0] wdat;
    logic [1:0] laneEn;
  } psc_regs_t;
  localparam psc_regs_t REGS_RST = '{laneEn: psc_pkg::LANE_RST, default: '0};
  psc_regs_t q, n;
  logic [31:0] merged;
  logic [31:0] status;

  // Word index match, low address bits ignored
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    return {a[7:2], 2'b00} == off;
  endfunction

  // Byte-lane merge of a write into an old value
  function automatic logic [31:0] mergeBytes(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction

  // Status word built from live sequencer state and the local go-pending and read-done flags
  always_comb begin
    status = '0;
    status[psc_pkg::ST_BUSY] = cmd.busy;
    status[psc_pkg::ST_INIT] = cmd.initDone;
    status[psc_pkg::ST_DEEPB] = cmd.deepActive;
    status[psc_pkg::ST_RDV] = q.rdSticky;
    status[psc_pkg::ST_NRD +: 2] = cmd.initReads;
    status[psc_pkg::ST_CODE +: 3] = cmd.stateCode;
    status[psc_pkg::ST_PEND] = q.goPend;
  end

  // Next state: both address and data may arrive in either order
  always_comb begin
    n = q;
    merged = '0;
    if (cmd.ack) n.goPend = 1'b0;
    if (cmd.ack) n.rdSticky = 1'b0;
    if (cmd.rdDone) n.rdSticky = 1'b1; // Completion wins over the clear
    if (awvalid && q.awReady) begin
      n.awHeld = 1'b1;
      n.awAddr = awaddr;
    end
    if (wvalid && q.wReady) begin
      n.wHeld = 1'b1;
      n.wData = wdata;
      n.wStrb = wstrb;
    end
    if (bready && q.bValid) n.bValid = 1'b0;
    if (n.awHeld && n.wHeld && !n.bValid) begin
      n.awHeld = 1'b0;
      n.wHeld = 1'b0;
      n.bValid = 1'b1;
      n.bResp = psc_pkg::RESP_OKAY;
      if (hit(n.awAddr, psc_pkg::REG_CTRL)) begin
        merged = mergeBytes({29'h0, q.ctrlDeep, q.ctrlWrite, 1'b0}, n.wData, n.wStrb);
        n.ctrlWrite = merged[psc_pkg::CTRL_WRITE];
        n.ctrlDeep = merged[psc_pkg::CTRL_DEEP];
        if (merged[psc_pkg::CTRL_GO]) n.goPend = 1'b1; // Set wins over the ack
      end else if (hit(n.awAddr, psc_pkg::REG_ADDR)) begin
        merged = mergeBytes({12'h000, q.addr}, n.wData, n.wStrb);
        n.addr = merged[19:0];
      end else if (hit(n.awAddr, psc_pkg::REG_WDATA)) begin
        merged = mergeBytes({14'h0, q.laneEn, q.wdat}, n.wData, n.wStrb);
        n.wdat = merged[15:0];
        n.laneEn = merged[psc_pkg::WD_LANE_LO +: 2];
      end else if (!hit(n.awAddr, psc_pkg::REG_RDATA) && !hit(n.awAddr, psc_pkg::REG_STATUS)) begin
        n.bResp = psc_pkg::RESP_SLVERR;
      end
    end
    n.awReady = !n.awHeld && !n.bValid;
    n.wReady = !n.wHeld && !n.bValid;
    if (rready && q.rValid) n.rValid = 1'b0;
    if (arvalid && q.arReady) begin
      n.rValid = 1'b1;
      n.rResp = psc_pkg::RESP_OKAY;
      n.rData = '0;
      if (hit(araddr, psc_pkg::REG_CTRL)) n.rData = {29'h0, q.ctrlDeep, q.ctrlWrite, q.goPend};
      else if (hit(araddr, psc_pkg::REG_ADDR)) n.rData = {12'h000, q.addr};
      else if (hit(araddr, psc_pkg::REG_WDATA)) n.rData = {14'h0, q.laneEn, q.wdat};
      else if (hit(araddr, psc_pkg::REG_RDATA)) n.rData = {16'h0000, cmd.rdData};
      else if (hit(araddr, psc_pkg::REG_STATUS)) n.rData = status;
      else n.rResp = psc_pkg::RESP_SLVERR;
    end
    n.arReady = !n.rValid;
  end

  // State register, frozen while the clock enable is low
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= REGS_RST;
    end else if (ce) begin
      q <= n;
    end
  end

  assign awready = q.awReady;
  assign wready = q.wReady;
  assign bvalid = q.bValid;
  assign bresp = q.bResp;
  assign arready = q.arReady;
  assign rvalid = q.rValid;
  assign rdata = q.rData;
  assign rresp = q.rResp;
  assign cmd.go = q.goPend;
  assign cmd.isWrite = q.ctrlWrite;
  assign cmd.deepReq = q.ctrlDeep;
  assign cmd.addr = q.addr;
  assign cmd.wdata = q.wdat;
  assign cmd.laneEn = q.laneEn;
endmodule

// >>> dv/psc_ctrl_monitor.sv
// Pin protocol checker for the pseudo-SRAM host controller
`timescale 1ns/1ps
module psc_ctrl_monitor #(
  parameter int PWR_WAIT_CYC = 20
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Memory pins
  input wire logic chipSelN,
  input wire logic outEnN,
  input wire logic writeStrobeN,
  input wire logic lowLaneSelN,
  input wire logic highLaneSelN,
  input wire logic standbySel,
  input wire logic dataBusOeN
);
  logic [15:0] upCnt_q;
  logic [3:0] csFalls_q;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // Cycles since reset and chip-select pulses; both saturate so they never wrap
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      upCnt_q <= 16'h0000;
      csFalls_q <= 4'h0;
    end else begin
      if (upCnt_q != 16'hFFFF)
        upCnt_q <= upCnt_q + 16'h0001;
      if ($fell(chipSelN) && csFalls_q != 4'hF)
        csFalls_q <= csFalls_q + 4'h1;
    end
  end
  a_pwr_park: assert property (
    int'(upCnt_q) < PWR_WAIT_CYC |-> chipSelN && standbySel)
    else $error("pins moved during power wait");
  a_init_stby: assert property (csFalls_q < 4'h3 |-> standbySel)
    else $error("standby-select low before init reads done");
  a_init_quiet: assert property (
    !chipSelN && csFalls_q < 4'h3 |-> outEnN && writeStrobeN)
    else $error("init read not quiet");
  a_first_access: assert property (
    !outEnN || !writeStrobeN |-> csFalls_q >= 4'h3)
    else $error("access before three init reads");
  a_cs_span: assert property (
    $fell(chipSelN) |=> !chipSelN [*8] ##1 !chipSelN ##1 chipSelN)
    else $error("chip select pulse not ten cycles");
  a_we_span: assert property (
    $fell(writeStrobeN) |=> !writeStrobeN [*8] ##1 (writeStrobeN && !chipSelN))
    else $error("write strobe width wrong");
  a_oe_no_drive: assert property (!outEnN |-> dataBusOeN && writeStrobeN)
    else $error("bus driven or write strobe low in read");
  a_write_drives: assert property (!writeStrobeN |-> !dataBusOeN && !chipSelN)
    else $error("write without bus drive");
  a_deep_desel: assert property (!standbySel |-> chipSelN)
    else $error("standby-select low while selected");
  a_deep_exit: assert property ($rose(standbySel) |-> chipSelN [*8])
    else $error("access right after deep standby");
  c_write: cover property ($fell(writeStrobeN));
  c_read: cover property (!outEnN && !lowLaneSelN && highLaneSelN);
  c_deep: cover property ($fell(standbySel));
endmodule
bind psc_ctrl_top psc_ctrl_monitor #(.PWR_WAIT_CYC(PWR_WAIT_CYC)) u_mon (.core_clk(core_clk),
  .rst_n(rst_n), .chipSelN(chipSelN), .outEnN(outEnN), .writeStrobeN(writeStrobeN),
  .lowLaneSelN(lowLaneSelN), .highLaneSelN(highLaneSelN), .standbySel(standbySel),
  .dataBusOeN(dataBusOeN));

// >>> dv/psc_mem_model.sv
// Behavioural model of the 1M x 16 pseudo-SRAM device
`timescale 1ns/1ps
module psc_mem_model (
  // Control pins
  input wire logic chipSelN,
  input wire logic outEnN,
  input wire logic writeStrobeN,
  input wire logic lowLaneSelN,
  input wire logic highLaneSelN,
  input wire logic standbySel,
  // Address and data
  input wire logic [19:0] wordAddr,
  input wire logic [15:0] dataBusOut,
  input wire logic dataBusOeN,
  output logic [15:0] dataBusIn
);
  logic [15:0] mem [logic [19:0]]; // Sparse 1M words of 16 bits
  logic [15:0] rdWord, lastBus, wrWord;
  logic [1:0] devEn;
  // Unwritten or lost words read as the inverted address
  assign rdWord = mem.exists(wordAddr) ? mem[wordAddr] : ~wordAddr[15:0];
  // Read drives selected lanes only
  assign devEn[0] = !chipSelN && standbySel && !outEnN && writeStrobeN && !lowLaneSelN;
  assign devEn[1] = !chipSelN && standbySel && !outEnN && writeStrobeN && !highLaneSelN;
  // Undriven lanes show the inverse of their last level, no pull
  assign dataBusIn[7:0] = !dataBusOeN ? dataBusOut[7:0] : devEn[0] ? rdWord[7:0] : ~lastBus[7:0];
  assign dataBusIn[15:8] = !dataBusOeN ? dataBusOut[15:8] :
                           devEn[1] ? rdWord[15:8] : ~lastBus[15:8];
  // Remember the last driven level per lane
  always @* begin
    if (!dataBusOeN)
      lastBus = dataBusOut;
    if (devEn[0])
      lastBus[7:0] = rdWord[7:0];
    if (devEn[1])
      lastBus[15:8] = rdWord[15:8];
  end
  // Write lands at strobe end; both selects high aborts
  always @(posedge writeStrobeN) begin
    wrWord = rdWord;
    if (!lowLaneSelN)
      wrWord[7:0] = dataBusIn[7:0];
    if (!highLaneSelN)
      wrWord[15:8] = dataBusIn[15:8];
    if (!chipSelN && !(lowLaneSelN && highLaneSelN))
      mem[wordAddr] = wrWord;
  end
  // Deep standby loses every word
  always @(negedge standbySel) begin
    if (chipSelN)
      mem.delete();
  end
endmodule

// >>> dv/psc_ctrl_top_bench.sv
// Self-checking bench for the pseudo-SRAM host controller
`timescale 1ns/1ps
module psc_ctrl_top_bench;
  typedef struct packed {logic [31:0] d; logic [31:0] m; logic [1:0] r;} psc_exp_t;
  logic core_clk, rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic ce;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rdLast;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, lanes;
  logic chipSelN, outEnN, writeStrobeN, lowLaneSelN, highLaneSelN, standbySel, dataBusOeN;
  logic [19:0] wordAddr, adr;
  logic [15:0] dataBusOut, dataBusIn, base, nw, ex;
  psc_exp_t rdQ[$];
  logic [1:0] bQ[$];
  int errCount, checksDone;
  psc_ctrl_top #(.PWR_WAIT_CYC(20)) DUT (.core_clk, .rst_n, .ce, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .chipSelN, .outEnN,
    .writeStrobeN, .lowLaneSelN, .highLaneSelN, .standbySel, .wordAddr, .dataBusOut,
    .dataBusOeN, .dataBusIn);
  psc_mem_model u_mem (.chipSelN, .outEnN, .writeStrobeN, .lowLaneSelN, .highLaneSelN,
    .standbySel, .wordAddr, .dataBusOut, .dataBusOeN, .dataBusIn);
  // Free-running 100 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  task automatic closeOut();
    $display("checks %0d mismatches %0d", checksDone, errCount);
    if (errCount == 0 && checksDone > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic cmpRd(input logic [31:0] g, input logic [1:0] gr, input psc_exp_t e);
    checksDone++;
    if ((g & e.m) !== (e.d & e.m) || gr !== e.r) begin
      errCount++;
      $display("BAD t=%0t got=%h exp=%h", $time, {gr, g & e.m}, {e.r, e.d & e.m});
    end
  endtask
  task automatic cmpWr(input logic [1:0] g, input logic [1:0] e);
    checksDone++;
    if (g !== e) begin
      errCount++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // Master holds each channel until its own handshake, then waits for the answer
  task automatic axiWr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    logic awSeen, wSeen, bSeen;
    bQ.push_back(r);
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    // Handshakes read mid-cycle, where the levels seen by the next edge are settled
    do begin
      @(negedge core_clk);
      awSeen = s_axi_awvalid && s_axi_awready;
      wSeen = s_axi_wvalid && s_axi_wready;
      bSeen = s_axi_bvalid;
      @(posedge core_clk);
      if (awSeen)
        s_axi_awvalid <= 1'b0;
      if (wSeen)
        s_axi_wvalid <= 1'b0;
    end while (!bSeen);
    s_axi_bready <= 1'b0;
  endtask
  task automatic axiRd(input logic [7:0] a, input logic [31:0] d, m, input logic [1:0] r);
    logic arSeen, rSeen;
    rdQ.push_back('{d, m, r});
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(negedge core_clk);
      arSeen = s_axi_arvalid && s_axi_arready;
      rSeen = s_axi_rvalid;
      if (rSeen)
        rdLast = s_axi_rdata;
      @(posedge core_clk);
      if (arSeen)
        s_axi_arvalid <= 1'b0;
    end while (!rSeen);
    s_axi_rready <= 1'b0;
  endtask
  // Poll status until no request is pending and init is done
  task automatic waitIdle();
    repeat (2) @(posedge core_clk);
    for (int i = 0; i < 300; i++) begin
      axiRd(psc_pkg::REG_STATUS, 32'h0, 32'h0, psc_pkg::RESP_OKAY);
      if (rdLast[psc_pkg::ST_PEND] === 1'b0 && rdLast[psc_pkg::ST_BUSY] === 1'b0 &&
          rdLast[psc_pkg::ST_INIT] === 1'b1)
        break;
      if (i == 299)
        errCount++; // Poll limit ran out: counts as a mismatch
    end
  endtask
  task automatic memOp(input logic w, input logic [19:0] a, input logic [15:0] d,
                       input logic [1:0] l);
    axiWr(psc_pkg::REG_ADDR, {12'h000, a}, psc_pkg::RESP_OKAY);
    axiWr(psc_pkg::REG_WDATA, {14'h0000, l, d}, psc_pkg::RESP_OKAY);
    axiWr(psc_pkg::REG_CTRL, {30'h00000000, w, 1'b1}, psc_pkg::RESP_OKAY);
    waitIdle();
  endtask
  // Scoreboard pairs each response with the oldest note; sampled mid-cycle, clear of the edge
  always @(negedge core_clk) begin
    if (s_axi_bvalid && s_axi_bready)
      cmpWr(s_axi_bresp, bQ.pop_front());
    if (s_axi_rvalid && s_axi_rready)
      cmpRd(s_axi_rdata, s_axi_rresp, rdQ.pop_front());
  end
  // Watchdog sized well above the whole sequence
  initial begin
    #400000;
    errCount++;
    closeOut();
  end
  // Main sequence
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    s_axi_wstrb = 4'hF;
    ce = 1'b1;
    errCount = 0;
    checksDone = 0;
    rst_n = 1'b0;
    void'($urandom(32'h0CC04DF6));
    repeat (12) @(posedge core_clk);
    rst_n <= 1'b1;
    axiRd(psc_pkg::REG_STATUS, 32'h0, 32'h6, psc_pkg::RESP_OKAY);
    axiRd(psc_pkg::REG_WDATA, 32'h30000, 32'h30000, psc_pkg::RESP_OKAY);
    axiRd(8'h20, 32'h0, 32'hFFFFFFFF, psc_pkg::RESP_SLVERR);
    axiWr(8'h20, 32'h0, psc_pkg::RESP_SLVERR);
    adr = 20'(($urandom));
    memOp(1'b1, adr, 16'hA55A, 2'h3);
    memOp(1'b0, adr, 16'h0000, 2'h3);
    axiRd(psc_pkg::REG_RDATA, 32'hA55A, 32'hFFFF, psc_pkg::RESP_OKAY);
    $display("test reset and early request done");
    for (int l = 0; l < 4; l++) begin
      lanes = 2'(l);
      adr = 20'(($urandom));
      base = 16'($urandom);
      nw = 16'($urandom);
      ex = {lanes[1] ? nw[15:8] : base[15:8], lanes[0] ? nw[7:0] : base[7:0]};
      memOp(1'b1, adr, base, 2'h3);
      memOp(1'b1, adr, nw, lanes);
      memOp(1'b0, adr, 16'h0000, 2'h3);
      axiRd(psc_pkg::REG_RDATA, {16'h0, ex}, 32'hFFFF, psc_pkg::RESP_OKAY);
      memOp(1'b0, adr, 16'h0000, lanes);
      axiRd(psc_pkg::REG_RDATA, {16'h0, ex}, {16'h0, {8{lanes[1]}}, {8{lanes[0]}}},
            psc_pkg::RESP_OKAY);
    end
    $display("test lane writes and reads done");
    memOp(1'b1, adr, 16'h3CC3, 2'h3);
    axiWr(psc_pkg::REG_CTRL, 32'h4, psc_pkg::RESP_OKAY);
    repeat (4) @(posedge core_clk);
    axiRd(psc_pkg::REG_STATUS, 32'h4, 32'h4, psc_pkg::RESP_OKAY);
    axiWr(psc_pkg::REG_CTRL, 32'h0, psc_pkg::RESP_OKAY);
    // Frozen longer than the whole re-init, so init must still be pending afterwards
    ce <= 1'b0;
    repeat (60) @(posedge core_clk);
    ce <= 1'b1;
    axiRd(psc_pkg::REG_STATUS, 32'h0, 32'h2, psc_pkg::RESP_OKAY);
    waitIdle();
    memOp(1'b0, adr, 16'h0000, 2'h3);
    axiRd(psc_pkg::REG_RDATA, {16'h0, ~adr[15:0]}, 32'hFFFF, psc_pkg::RESP_OKAY);
    $display("test deep standby done");
    closeOut();
  end
endmodule
